// >>> shared/pnsmmd_pkg.sv
// package for the phy status and indirect manageable-device access block
// assumes a 32-bit axi4-lite slave with 16-bit registers in the low lanes
package pnsmmd_pkg;
    // ****************************************
    // register map (word index, byte address = 4 * index)
    // ****************************************
    localparam logic [7:0]  IDX_NEG_SPEED_STATUS = 8'h1F;
    localparam logic [7:0]  IDX_ACCESS_CONTROL   = 8'h0D;
    localparam logic [7:0]  IDX_INDEX_VALUE      = 8'h0E;
    localparam logic [7:0]  IDX_PHY_INPUTS       = 8'h10;
    localparam int          ADDR_W               = 8;

    // ****************************************
    // fields
    // ****************************************
    localparam int          AUTODONE_BIT   = 12;
    localparam int          FIXED_LSB      = 5;
    localparam int          FIXED_MSB      = 11;
    localparam logic [6:0]  FIXED_RESET    = 7'h02;
    localparam int          SPEED_LSB      = 2;
    localparam int          SPEED_MSB      = 4;
    localparam logic [2:0]  SPEED_10_HALF  = 3'h1;
    localparam logic [2:0]  SPEED_100_HALF = 3'h2;
    localparam logic [2:0]  SPEED_10_FULL  = 3'h5;
    localparam logic [2:0]  SPEED_100_FULL = 3'h6;
    localparam int          FUNC_LSB       = 14;
    localparam int          FUNC_MSB       = 15;
    localparam logic [1:0]  FUNC_ADDRESS   = 2'h0;
    localparam logic [1:0]  FUNC_DATA      = 2'h1;
    localparam int          DEV_LSB        = 0;
    localparam int          DEV_MSB        = 4;

    // ****************************************
    // manageable devices and indices
    // ****************************************
    localparam logic [4:0]  DEV_CODING     = 5'h03;
    localparam logic [4:0]  DEV_AUTONEG    = 5'h07;
    localparam logic [4:0]  DEV_VENDOR     = 5'h1E;
    localparam int          SLOT_W         = 5;
    localparam int          SLOTS          = 32;
    localparam logic [4:0]  SLOT_NONE      = 5'h1F;

    // ****************************************
    // axi response codes and reset values
    // ****************************************
    localparam logic [1:0]  RESP_OKAY      = 2'h0;
    localparam logic [1:0]  RESP_SLVERR    = 2'h2;
    localparam logic [15:0] ACCESS_RESET   = 16'h0000;
    localparam logic [15:0] INDEX_RESET    = 16'h0000;

    // map device and index to a storage slot, or SLOT_NONE
    function automatic logic [4:0] pnsmmd_slot(input logic [4:0] dev, input logic [15:0] idx);
        logic [4:0] s;
        s = SLOT_NONE;
        if (dev == DEV_CODING) begin
            case (idx)
                16'h0000: s = 5'h00;
                16'h0001: s = 5'h01;
                16'h0005: s = 5'h02;
                16'h0006: s = 5'h03;
                16'h0014: s = 5'h04;
                16'h0016: s = 5'h05;
                16'h8010: s = 5'h06;
                16'h8011: s = 5'h07;
                16'h8012: s = 5'h08;
                16'h8061: s = 5'h11;
                16'h8062: s = 5'h12;
                16'h8063: s = 5'h13;
                default: begin
                    if (idx >= 16'h8021 && idx <= 16'h8028) begin
                        s = 5'(idx - 16'h8021 + 16'h0009);
                    end
                end
            endcase
        end else if (dev == DEV_AUTONEG) begin
            case (idx)
                16'h0005: s = 5'h14;
                16'h0006: s = 5'h15;
                16'h003C: s = 5'h16;
                16'h003D: s = 5'h17;
                default:  s = SLOT_NONE;
            endcase
        end else if (dev == DEV_VENDOR) begin
            case (idx)
                16'h0002: s = 5'h18;
                16'h0003: s = 5'h19;
                16'h0005: s = 5'h1A;
                16'h0006: s = 5'h1B;
                16'h0008: s = 5'h1C;
                16'h000E: s = 5'h1D;
                16'h000F: s = 5'h1E;
                default:  s = SLOT_NONE;
            endcase
        end
        return s;
    endfunction

    typedef enum logic [1:0] {PNS_RD_IDLE, PNS_RD_FETCH, PNS_RD_RESP} pnsmmd_rd_state_t;
endpackage

// >>> rtl/pnsmmd_store.sv
// small memory holding the manageable-device register contents
// assumes one write port and one read port on the same clock
`timescale 1ns/10ps
module pnsmmd_store
    import pnsmmd_pkg::*;
(
    input  wire logic              mclk,
    input  wire logic              wr_en,
    input  wire logic [SLOT_W-1:0] wr_slot,
    input  wire logic [15:0]       wr_data,
    input  wire logic [SLOT_W-1:0] rd_slot,
    output logic      [15:0]       rd_data
);
    // ****************************************
    // storage
    // ****************************************
    logic [15:0] mem [SLOTS];

    // registered read; unreset storage so software sees undefined contents until a slot is written
    always_ff @(posedge mclk) begin
        if (wr_en) begin
            mem[wr_slot] <= wr_data;
        end
        rd_data <= mem[rd_slot];
    end
endmodule // pnsmmd_store

// >>> rtl/pnsmmd_sync.sv
// two-flop synchroniser for a bus of levels
// assumes inputs are quasi-static levels from outside the clock domain
`timescale 1ns/10ps
module pnsmmd_sync #(
    parameter int W = 4
) (
    input  wire logic         mclk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_reg;

    // first stage feeds only the second
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            meta_reg <= '0;
            q        <= '0;
        end else begin
            meta_reg <= d;
            q        <= meta_reg;
        end
    end
endmodule // pnsmmd_sync

// >>> rtl/pnsmmd_top.sv
// phy status register and indirect manageable-device access, axi4-lite slave
// assumes phy status levels arrive asynchronously and are synchronised here
// What this block does
// - status register, sixteen bits wide, at word index 31
// - bit 12 reads one only after negotiation completes; reset zero
// - bits 11:5 reset to 0000010b; written value stored, software ignores readback
// - bits 4:2 report resolved speed and duplex code
// - manageable-device registers reached only through control and index/value registers
// - three devices: 3 coding, 7 negotiation, 30 vendor space
// - device registers laid out per standard management register conventions
// - host writes sixteen-bit index; block latches it as pending index
// - data phase read returns selected register; write stores into it
// - device 3 decodes its listed control, wake and address indices
// - device 7 decodes indices 5, 6, 60, 61
// - device 30 decodes indices 2, 3, 5, 6, 8, 14, 15
`timescale 1ns/10ps
module pnsmmd_top
    import pnsmmd_pkg::*;
(
    input  wire logic              mclk,
    input  wire logic              rst_n,
    // axi4-lite write address
    input  wire logic [ADDR_W+1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    // axi4-lite write data
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    // axi4-lite write response
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    // axi4-lite read address
    input  wire logic [ADDR_W+1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    // axi4-lite read data
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    // phy status levels
    input  wire logic              autoneg_done,
    input  wire logic [2:0]        resolved_speed
);
    // ****************************************
    // reset release and input synchronisers
    // ****************************************
    logic       rst_meta_reg;
    logic       rst_sync_reg;
    logic [3:0] phy_q;

    // release synchronised so all flops leave reset on one edge
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end

    pnsmmd_sync #(.W(4)) u_sync (
        .mclk  (mclk),
        .rst_n (rst_sync_reg),
        .d     ({autoneg_done, resolved_speed}),
        .q     (phy_q)
    );

    // ****************************************
    // register state
    // ****************************************
    logic [6:0]        fixed_field_reg;
    logic [15:0]       indirect_access_control_reg;
    logic [15:0]       indirect_index_value_reg;
    logic [15:0]       phy_negotiation_speed_status;
    logic [4:0]        target_device_field;
    logic [1:0]        access_function;
    logic              data_phase;
    logic [SLOT_W-1:0] sel_slot;
    logic              sel_valid;

    assign target_device_field = indirect_access_control_reg[DEV_MSB:DEV_LSB];
    assign access_function     = indirect_access_control_reg[FUNC_MSB:FUNC_LSB];
    assign data_phase          = (access_function == FUNC_DATA);
    // slot chosen from device and pending index
    assign sel_slot  = pnsmmd_slot(target_device_field, indirect_index_value_reg);
    assign sel_valid = (sel_slot != SLOT_NONE);

    // status word: reserved 15:13 and 1:0 read zero
    assign phy_negotiation_speed_status = {3'h0,
                                           phy_q[3],
                                           fixed_field_reg,
                                           phy_q[2:0],
                                           2'h0};

    // ****************************************
    // write channel
    // ****************************************
    logic [ADDR_W+1:0] aw_addr_reg;
    logic              aw_held_reg;
    logic [31:0]       w_data_reg;
    logic [3:0]        w_strb_reg;
    logic              w_held_reg;
    logic              wr_fire;
    logic [ADDR_W-1:0] wr_idx;
    logic [15:0]       wr_val;
    logic              wr_lo;
    logic              wr_hi;

    // address and data accepted independently, held until both are present; neither is taken again while the response is pending
    assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
    assign s_axi_wready  = !w_held_reg && !s_axi_bvalid;
    assign wr_fire       = aw_held_reg && w_held_reg && !s_axi_bvalid;
    assign wr_idx        = aw_addr_reg[ADDR_W+1:2];
    assign wr_lo         = w_strb_reg[0];
    assign wr_hi         = w_strb_reg[1];

    // capture of write address and data
    always_ff @(posedge mclk or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            aw_addr_reg <= '0;
            aw_held_reg <= 1'b0;
            w_data_reg  <= '0;
            w_strb_reg  <= '0;
            w_held_reg  <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_addr_reg <= s_axi_awaddr;
                aw_held_reg <= 1'b1;
            end else if (wr_fire) begin
                aw_held_reg <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
                w_held_reg <= 1'b1;
            end else if (wr_fire) begin
                w_held_reg <= 1'b0;
            end
        end
    end

    // merge byte lanes into the old value of the target
    function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] nw,
                                          input logic lo, input logic hi);
        return {hi ? nw[15:8] : old[15:8], lo ? nw[7:0] : old[7:0]};
    endfunction

    assign wr_val = w_data_reg[15:0];

    // write response; unmapped offsets answer slverr
    always_ff @(posedge mclk or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (wr_idx == IDX_NEG_SPEED_STATUS || wr_idx == IDX_ACCESS_CONTROL ||
                             wr_idx == IDX_INDEX_VALUE || wr_idx == IDX_PHY_INPUTS)
                            ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ****************************************
    // register updates
    // ****************************************
    logic [15:0]       fixed_merged;

    // merge written lanes;
    // only 11:5 is kept
    assign fixed_merged = merge({4'h0, fixed_field_reg, 5'h00}, wr_val, wr_lo, wr_hi);

    // fixed field keeps whatever software writes; it steers nothing else
    always_ff @(posedge mclk or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            fixed_field_reg <= FIXED_RESET;
        end else if (wr_fire && wr_idx == IDX_NEG_SPEED_STATUS) begin
            fixed_field_reg <= fixed_merged[FIXED_MSB:FIXED_LSB];
        end
    end

    // access control selects function and device
    always_ff @(posedge mclk or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            indirect_access_control_reg <= ACCESS_RESET;
        end else if (wr_fire && wr_idx == IDX_ACCESS_CONTROL) begin
            indirect_access_control_reg <= merge(indirect_access_control_reg, wr_val,
                                                 wr_lo, wr_hi);
        end
    end

    // index/value: in address phase the write becomes the pending index
    always_ff @(posedge mclk or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            indirect_index_value_reg <= INDEX_RESET;
        end else if (wr_fire && wr_idx == IDX_INDEX_VALUE && access_function == FUNC_ADDRESS) begin
            indirect_index_value_reg <= merge(indirect_index_value_reg, wr_val,
                                              wr_lo, wr_hi);
        end
    end

    // ****************************************
    // device register storage
    // ****************************************
    logic              st_wr_en;
    logic [15:0]       st_rd_data;
    logic [15:0]       st_wr_data;

    // data-phase write lands in the selected slot only; undecoded is dropped
    assign st_wr_en   = wr_fire && wr_idx == IDX_INDEX_VALUE && data_phase && sel_valid;
    assign st_wr_data = wr_val; // byte strobes ignored; all sixteen bits are written

    // slot read live so the word is ready at fetch
    pnsmmd_store u_store (
        .mclk    (mclk),
        .wr_en   (st_wr_en),
        .wr_slot (sel_slot),
        .wr_data (st_wr_data),
        .rd_slot (sel_slot),
        .rd_data (st_rd_data)
    );

    // ****************************************
    // read channel
    // ****************************************
    pnsmmd_rd_state_t  rd_state_reg;
    logic [ADDR_W-1:0] rd_idx_reg;
    logic              rd_hit_reg;

    assign s_axi_arready = (rd_state_reg == PNS_RD_IDLE);

    // read sequencing: one fetch cycle for the memory's registered output
    always_ff @(posedge mclk or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            rd_state_reg   <= PNS_RD_IDLE;
            rd_idx_reg     <= '0;
            rd_hit_reg     <= 1'b0;
        end else begin
            case (rd_state_reg)
                PNS_RD_IDLE: begin
                    if (s_axi_arvalid) begin
                        rd_idx_reg     <= s_axi_araddr[ADDR_W+1:2];
                        rd_hit_reg     <= data_phase && sel_valid;
                        rd_state_reg   <= PNS_RD_FETCH;
                    end
                end
                PNS_RD_FETCH: rd_state_reg <= PNS_RD_RESP;
                PNS_RD_RESP: begin
                    if (s_axi_rready) begin
                        rd_state_reg <= PNS_RD_IDLE;
                    end
                end
                default: rd_state_reg <= PNS_RD_IDLE;
            endcase
        end
    end

    // read data registered in the fetch cycle
    always_ff @(posedge mclk or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            s_axi_rdata  <= '0;
            s_axi_rresp  <= RESP_OKAY;
            s_axi_rvalid <= 1'b0;
        end else if (rd_state_reg == PNS_RD_FETCH) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= RESP_OKAY;
            case (rd_idx_reg)
                IDX_NEG_SPEED_STATUS: s_axi_rdata <= {16'h0000, phy_negotiation_speed_status};
                IDX_ACCESS_CONTROL:   s_axi_rdata <= {16'h0000, indirect_access_control_reg};
                IDX_INDEX_VALUE: begin
                    // data phase: selected contents, or zero when undecoded
                    if (rd_hit_reg) begin
                        s_axi_rdata <= {16'h0000, st_rd_data};
                    end else if (data_phase) begin
                        s_axi_rdata <= '0;
                    end else begin
                        s_axi_rdata <= {16'h0000, indirect_index_value_reg};
                    end
                end
                IDX_PHY_INPUTS:       s_axi_rdata <= {28'h0000000, phy_q};
                default: begin
                    s_axi_rdata <= '0;
                    s_axi_rresp <= RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule // pnsmmd_top

// >>> verification/pnsmmd_asserts.sv
// checker for the phy status and indirect access block
// assumes it is bound to pnsmmd_top and sees only its ports
`timescale 1ns/10ps
module pnsmmd_asserts
    import pnsmmd_pkg::*;
(
    input wire logic              mclk,
    input wire logic              rst_n,
    input wire logic              s_axi_awvalid,
    input wire logic              s_axi_awready,
    input wire logic              s_axi_wvalid,
    input wire logic              s_axi_wready,
    input wire logic [1:0]        s_axi_bresp,
    input wire logic              s_axi_bvalid,
    input wire logic              s_axi_bready,
    input wire logic [ADDR_W+1:0] s_axi_araddr,
    input wire logic              s_axi_arvalid,
    input wire logic              s_axi_arready,
    input wire logic [31:0]       s_axi_rdata,
    input wire logic [1:0]        s_axi_rresp,
    input wire logic              s_axi_rvalid,
    input wire logic              s_axi_rready,
    input wire logic              autoneg_done,
    input wire logic [2:0]        resolved_speed
);
    // ****************
    // helpers
    // ****************
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);
    logic       ar_take;
    logic       ar_st;
    logic       ar_map;
    logic [3:0] prev_reg;
    logic [2:0] still_reg;
    // address decode of the read channel
    assign ar_take = s_axi_arvalid && s_axi_arready;
    assign ar_st   = ar_take && s_axi_araddr[9:2] == IDX_NEG_SPEED_STATUS;
    assign ar_map  = s_axi_araddr[9:2] inside {IDX_NEG_SPEED_STATUS, IDX_ACCESS_CONTROL,
                                               IDX_INDEX_VALUE, IDX_PHY_INPUTS};
    // phy levels judged only once settled, the synchroniser hides fresh moves
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            prev_reg  <= 4'h0;
            still_reg <= 3'h0;
        end else begin
            prev_reg <= {autoneg_done, resolved_speed};
            if (prev_reg != {autoneg_done, resolved_speed}) begin
                still_reg <= 3'h0;
            end else if (still_reg != 3'h7) begin
                still_reg <= still_reg + 3'h1;
            end
        end
    end
    // ****************
    // properties
    // ****************
    a_read_latency: assert property (ar_take |-> ##2 s_axi_rvalid)
        else $error("read answer late");
    a_read_busy: assert property (ar_take |=> !s_axi_arready ##1 !s_axi_arready)
        else $error("second read accepted early");
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> ##[1:2] s_axi_bvalid)
        else $error("write answer late");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
        && $stable(s_axi_bresp))
        else $error("write answer dropped");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
        && $stable(s_axi_rdata) && $stable(s_axi_rresp))
        else $error("read answer dropped");
    a_write_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted during answer");
    a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0)
        else $error("upper read lanes not zero");
    a_status_done: assert property (ar_st && still_reg >= 3'h3 |->
        ##2 s_axi_rdata[15:12] == {3'h0, $past(autoneg_done, 3)})
        else $error("negotiation bit wrong");
    a_status_speed: assert property (ar_st && still_reg >= 3'h3 |->
        ##2 s_axi_rdata[4:0] == {$past(resolved_speed, 3), 2'h0})
        else $error("speed field wrong");
    a_unmapped_read: assert property (ar_take && !ar_map |->
        ##2 s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
endmodule // pnsmmd_asserts

bind pnsmmd_top pnsmmd_asserts u_chk (.mclk, .rst_n, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .autoneg_done, .resolved_speed);

// >>> verification/testbench.sv
// self-checking bench for pnsmmd_top, driven as an axi4-lite master
// assumes the package and the checker with its bind are compiled first
`timescale 1ns/10ps
module testbench
    import pnsmmd_pkg::*;
;
    // ****************
    // signals
    // ****************
    localparam logic [9:0] A_ST = 10'h07C;
    localparam logic [9:0] A_CT = 10'h034;
    localparam logic [9:0] A_IV = 10'h038;
    logic        mclk, rst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic        s_axi_rready, autoneg_done;
    logic [9:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, seed, rd;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
    logic [2:0]  resolved_speed;
    logic [15:0] mem [31];
    int          fail_count, cmp_count, cycles;
    logic [15:0] idx_tbl [31] = '{16'h0000, 16'h0001, 16'h0005, 16'h0006, 16'h0014, 16'h0016,
        16'h8010, 16'h8011, 16'h8012, 16'h8021, 16'h8022, 16'h8023, 16'h8024, 16'h8025,
        16'h8026, 16'h8027, 16'h8028, 16'h8061, 16'h8062, 16'h8063, 16'h0005, 16'h0006,
        16'h003C, 16'h003D, 16'h0002, 16'h0003, 16'h0005, 16'h0006, 16'h0008, 16'h000E, 16'h000F};
    logic [20:0] bad [6] = '{{5'h01, 16'h0000}, {5'h03, 16'h0002}, {5'h03, 16'h8029},
        {5'h07, 16'h003E}, {5'h1E, 16'h0010}, {5'h1F, 16'h0003}};

    pnsmmd_top i_dut (.mclk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .autoneg_done, .resolved_speed);

    // ****************
    // helpers
    // ****************
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    // device number follows the table position
    function automatic logic [4:0] dev_of(input int i);
        return (i < 20) ? 5'h03 : (i < 24) ? 5'h07 : 5'h1E;
    endfunction
    function automatic logic [31:0] st_exp(input logic an, input logic [2:0] sp);
        return {19'h0, an, 7'h02, sp, 2'h0};
    endfunction
    task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", n, exp, seen);
        end
    endtask
    // address and data offered together, each released when taken
    task automatic wr(input logic [9:0] a, input logic [31:0] d);
        logic aw_d;
        logic w_d;
        aw_d = 1'b0;
        w_d = 1'b0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(aw_d && w_d)) begin
            @(posedge mclk);
            if (s_axi_awvalid && s_axi_awready) begin
                aw_d = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_d = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        while (s_axi_bvalid !== 1'b1) @(posedge mclk);
        rs = s_axi_bresp;
        s_axi_bready <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic rdr(input logic [9:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge mclk); while (!(s_axi_arvalid && s_axi_arready));
        s_axi_arvalid <= 1'b0;
        while (s_axi_rvalid !== 1'b1) @(posedge mclk);
        rd = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge mclk);
    endtask
    // address phase, index, then data phase on the same device
    task automatic sel(input logic [4:0] dv, input logic [15:0] ix);
        wr(A_CT, {16'h0, 2'h0, 9'h0, dv});
        wr(A_IV, {16'h0, ix});
        wr(A_CT, {16'h0, 2'h1, 9'h0, dv});
    endtask
    // read back in reverse so aliasing between slots shows
    task automatic verify();
        for (int i = 30; i >= 0; i--) begin
            sel(dev_of(i), idx_tbl[i]);
            rdr(A_IV);
            chk("device reg", rd, {16'h0, mem[i]});
        end
    endtask
    task automatic results();
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // ****************
    // clock, watchdog, sequence
    // ****************
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    // a hang counts as a mismatch
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 30000) begin
            fail_count++;
            results();
        end
    end
    initial begin
        {rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hF;
        autoneg_done = 1'b0;
        resolved_speed = 3'h1;
        seed = 32'hEE90;
        repeat (20) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (3) @(posedge mclk);
        rdr(A_ST);
        chk("status reset", rd, st_exp(1'b0, 3'h1));
        rdr(A_CT);
        chk("control reset", rd, 32'h0);
        $display("test reset done");
        for (int i = 0; i < 8; i++) begin
            seed = xs(seed);
            autoneg_done <= i[0];
            resolved_speed <= {i[2], i[1], ~i[1]};
            wr(A_ST, {19'h0, seed[0], 7'h02, seed[3:1], 2'h0});
            rdr(A_ST);
            chk("status", rd, st_exp(i[0], {i[2], i[1], ~i[1]}));
        end
        $display("test status done");
        wr(A_CT, {16'h0, 2'h0, 9'h0, 5'h03});
        wr(A_IV, 32'h8063);
        rdr(A_IV);
        chk("pending index", rd, 32'h8063);
        for (int i = 0; i < 31; i++) begin
            seed = xs(seed);
            mem[i] = seed[15:0];
            sel(dev_of(i), idx_tbl[i]);
            wr(A_IV, {16'h0, mem[i]});
            chk("write resp", {30'h0, rs}, 32'h0);
        end
        verify();
        $display("test device regs done");
        for (int i = 0; i < 6; i++) begin
            sel(bad[i][20:16], bad[i][15:0]);
            wr(A_IV, 32'hFFFF);
            rdr(A_IV);
            chk("undecoded", rd, 32'h0);
        end
        rdr(10'h000);
        chk("unmapped read", {rs, rd[29:0]}, {2'h2, 30'h0});
        wr(10'h3FC, 32'hFFFF);
        chk("unmapped write", {30'h0, rs}, 32'h2);
        verify();
        $display("test undecoded done");
        results();
    end
endmodule // testbench
